// ==== test/fcrc_cpu_model.sv ====
// processor core model issuing flash bus cycles from internal ram
`timescale 1ns/100ps
`default_nettype none
module fcrc_cpu_model (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  bus_rdata,
  output var  logic        bus_wr,
  output var  logic        bus_rd,
  output var  logic [19:0] bus_addr,
  output var  logic [7:0]  bus_wdata
);
  // code runs from ram, no fetch is made from the array
  // callers aim program writes at both the user and the boot area
  initial {bus_wr, bus_rd, bus_addr, bus_wdata} = 30'h0;
  // released lines show the inverse, never a stale value
  task automatic idle;
    {bus_wr, bus_rd} = 2'h0;
    bus_addr = ~bus_addr;
    bus_wdata = ~bus_wdata;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'h1;
    @(negedge clk_sys);
    idle;
  endtask
  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    bus_addr = a;
    bus_rd = 1'h1;
    @(negedge clk_sys);
    d = bus_rdata;
    idle;
  endtask
endmodule
`default_nettype wire

// ==== test/fcrc_props.sv ====
// port assertions for the flash rewrite control block
`timescale 1ns/100ps
`default_nettype none
`include "fcrc_defines.svh"
module fcrc_props #(
  parameter int unsigned ERASE_CYC = `FCRC_ERASE_CYC
) (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic [1:0]  mode_pin,
  input wire logic        bus_rd,
  input wire logic [19:0] bus_addr,
  input wire logic [7:0]  bus_rdata,
  input wire logic        arr_prog,
  input wire logic        arr_erase,
  input wire logic        arr_verify,
  input wire logic [19:0] arr_addr,
  input wire logic        busy,
  input wire logic        rejected
);
  localparam logic [19:0] boot_lo = `FCRC_BOOT_BASE;
  localparam logic [19:0] boot_hi = `FCRC_BOOT_BASE + `FCRC_BOOT_SIZE;
  logic [21:0] bcnt_r;
  logic [21:0] bcnt_nxt;
  // counts only enabled cycles, since ce low freezes the op timer
  always_comb bcnt_nxt = busy ? bcnt_r + {21'h0, ce} : 22'h0;
  always_ff @(posedge clk_sys) bcnt_r <= srst ? 22'h0 : bcnt_nxt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  chk_start_busy: assert property ((arr_prog || arr_erase) |=> busy)
    else $error("busy did not follow an array start");
  // start pulse and busy rise on the same edge, never during an operation
  chk_start_idle: assert property ($rose(arr_prog || arr_erase) |->
    $rose(busy))
    else $error("array start while busy");
  chk_busy_len: assert property ($fell(busy) |->
    (bcnt_r == `FCRC_PROG_CYC || bcnt_r == ERASE_CYC))
    else $error("busy length wrong");
  chk_boot_guard: assert property ((arr_prog && mode_pin != 2'h1) |->
    !(arr_addr >= boot_lo && arr_addr < boot_hi))
    else $error("boot area programmed outside parallel mode");
  chk_rej_idle: assert property (rejected |-> !arr_prog ##1 !busy)
    else $error("rejected program still started");
  // ce low legally stretches the pulse, so only enabled edges count
  chk_prog_once: assert property ((arr_prog && ce) |=> !arr_prog)
    else $error("program start longer than one cycle");
  chk_ready_bit: assert property ((bus_rd && ce && bus_addr ==
    `FCRC_CTRL0_ADDR) |=> bus_rdata[0] == !$past(busy))
    else $error("ready bit wrong");
  chk_verify_rd: assert property ($rose(arr_verify) |-> $past(bus_rd))
    else $error("verify pulse without a read");
  chk_reset_idle: assert property ($fell(srst) |->
    !busy && !arr_prog && !arr_erase)
    else $error("not idle after reset");
  cover property (arr_prog);
  cover property (arr_erase);
  cover property (rejected);
  cover property (arr_verify);
endmodule
bind fcrc_ctrl fcrc_props #(.ERASE_CYC(ERASE_CYC)) chk_u (
  .clk_sys    (clk_sys),
  .srst       (srst),
  .ce         (ce),
  .mode_pin   (mode_pin),
  .bus_rd     (bus_rd),
  .bus_addr   (bus_addr),
  .bus_rdata  (bus_rdata),
  .arr_prog   (arr_prog),
  .arr_erase  (arr_erase),
  .arr_verify (arr_verify),
  .arr_addr   (arr_addr),
  .busy       (busy),
  .rejected   (rejected)
);
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the flash rewrite control block
`timescale 1ns/100ps
`default_nettype none
`include "fcrc_defines.svh"
module tb_top;
  typedef struct packed {
    logic [1:0]  m;
    logic [19:0] a;
    logic        p;
    logic        r;
  } fcrc_row_t;
  localparam logic [19:0] cmd_a = `FCRC_CMD_ADDR;
  localparam logic [19:0] ctl_a = `FCRC_CTRL0_ADDR;
  logic        clk_sys, srst, ce, protect_pin, bus_wr, bus_rd, fetch_block;
  logic        arr_prog, arr_erase, arr_verify, busy, rejected;
  logic [1:0]  mode_pin;
  logic [19:0] bus_addr, arr_addr;
  logic [7:0]  bus_wdata, bus_rdata, arr_wdata, d;
  int          num_errors, checks;
  // four-state so an unknown strobe spoils the count instead of vanishing
  integer      prog_n, erase_n, ver_n, rej_n, busy_n;
  fcrc_row_t   rows [6] = '{'{2'h0, 20'h10000, 1'h1, 1'h0},
    '{2'h0, 20'hFF000, 1'h0, 1'h1}, '{2'h0, 20'hFFDFF, 1'h0, 1'h1},
    '{2'h0, 20'hFFE00, 1'h1, 1'h0}, '{2'h3, 20'hFF000, 1'h0, 1'h1},
    '{2'h1, 20'hFF000, 1'h1, 1'h0}};
  fcrc_ctrl #(.ERASE_CYC(50)) dut_u (.clk_sys(clk_sys), .srst(srst),
    .ce(ce), .mode_pin(mode_pin), .protect_pin(protect_pin),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .fetch_block(fetch_block), .arr_prog(arr_prog), .arr_erase(arr_erase),
    .arr_verify(arr_verify), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .busy(busy), .rejected(rejected));
  fcrc_cpu_model cpu_u (.clk_sys(clk_sys), .bus_rdata(bus_rdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata));
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    prog_n += arr_prog;
    erase_n += arr_erase;
    ver_n += arr_verify;
    rej_n += rejected;
    busy_n += busy && ce;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic clr;
    {prog_n, erase_n, ver_n, rej_n, busy_n} = '0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // whole run is near 15k cycles
  initial begin
    #400000;
    num_errors++;
    summarize;
  end
  initial begin
    {srst, ce, protect_pin, mode_pin} = 5'h18;
    cyc(20);
    srst = 1'h0;
    cpu_u.rd(ctl_a, d);
    chk(d, 8'h01);
    cpu_u.wr(ctl_a, 8'h02);
    cpu_u.rd(ctl_a, d);
    chk(d[1:0], 2'h3);
    chk(fetch_block, 1'h1);
    $display("reset and enable done");
    for (int i = 0; i < 6; i++) begin
      mode_pin = rows[i].m;
      cyc(5);
      clr;
      cpu_u.wr(cmd_a, `FCRC_CMD_PROG);
      cpu_u.wr(rows[i].a, 8'h5A);
      cyc(2100);
      chk(prog_n, rows[i].p);
      chk(rej_n, rows[i].r);
      chk(busy_n, rows[i].p ? 2000 : 0);
      if (rows[i].p) chk({arr_wdata, arr_addr}, {8'h5A, rows[i].a});
      $display("row %0d done", i);
    end
    mode_pin = 2'h0;
    cyc(5);
    clr;
    cpu_u.wr(cmd_a, `FCRC_CMD_ERASE);
    cpu_u.wr(cmd_a, `FCRC_CMD_ERASE);
    cyc(80);
    cpu_u.wr(cmd_a, `FCRC_CMD_ERASE);
    cpu_u.wr(cmd_a, `FCRC_CMD_READ);
    cyc(80);
    chk(erase_n, 1);
    chk(busy_n, 50);
    $display("erase done");
    clr;
    cpu_u.wr(cmd_a, `FCRC_CMD_PROG);
    cpu_u.wr(20'h00010, 8'h11);
    cpu_u.wr(cmd_a, `FCRC_CMD_ERASE);
    cpu_u.wr(cmd_a, `FCRC_CMD_ERASE);
    ce = 1'h0;
    cyc(10);
    ce = 1'h1;
    cyc(2100);
    chk(prog_n, 1);
    chk(erase_n, 0);
    chk(busy_n, 2000);
    $display("busy guard done");
    foreach (rows[k]) if (k < 2) begin
      clr;
      cpu_u.wr(cmd_a, `FCRC_CMD_RESET);
      cpu_u.wr(cmd_a, `FCRC_CMD_RESET);
      cpu_u.wr(cmd_a, k ? 8'h55 : `FCRC_CMD_READ);
      cpu_u.wr(20'h00020, 8'h33);
      cyc(5);
      chk(prog_n, 0);
    end
    clr;
    cpu_u.wr(cmd_a, `FCRC_CMD_PVERIFY);
    cpu_u.rd(20'h00010, d);
    cpu_u.wr(cmd_a, `FCRC_CMD_EVERIFY);
    cpu_u.rd(20'h00010, d);
    cyc(2);
    chk(ver_n, 2);
    cpu_u.wr(ctl_a, 8'h00);
    cyc(2);
    chk(fetch_block, 1'h0);
    {mode_pin, protect_pin} = 3'h3;
    cyc(5);
    chk(fetch_block, 1'h1);
    $display("verify and fetch done");
    summarize;
  end
endmodule
`default_nettype wire

// ==== verilog/fcrc_ctrl.sv ====
// flash rewrite control: command decode, area guard, fetch gating
`timescale 1ns/100ps
`default_nettype none
`include "fcrc_defines.svh"
// Functional notes
// - The array works in parallel programmer, serial programmer or processor rewrite mode.
// - Program and erase start only from software commands, never from plain writes.
// - Array reads are blocked while parallel mode has read-out protection on.
// - A separate boot area of 3.5 kilobytes forms one erase division.
// - Boot area program or erase is accepted only in parallel programmer mode; the code guards program only, erase starts in any mode.
// - The boot area cannot be overwritten with a user rewrite program.
// - Rewrite mode is run through the control and command registers.
// - In rewrite mode only the user area changes; boot area attempts do nothing; the code guards program only, erase starts in any mode.
// - While rewrite mode is on the array serves no processor fetch.
// - The rewrite program may be loaded from the user or the boot area first.
// - Control sits at bytes 03B4h and 03B5h, command at byte 03B6h.
// - Codes: read 00, program 40, verify C0, erase 20 twice, verify A0, reset FF twice.
// - Read mode follows reset and the reset command until another command.
// - Program takes 20 us and erase 20 ms.
module fcrc_ctrl
  import fcrc_pkg::*;
#(
  parameter int unsigned ERASE_CYC = `FCRC_ERASE_CYC
) (
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  input  wire logic                    ce,
  input  wire logic [1:0]              mode_pin,
  input  wire logic                    protect_pin,
  input  wire logic                    bus_wr,
  input  wire logic                    bus_rd,
  input  wire logic [`FCRC_ADDR_W-1:0] bus_addr,
  input  wire logic [7:0]              bus_wdata,
  output var  logic [7:0]              bus_rdata,
  output var  logic                    fetch_block,
  output var  logic                    arr_prog,
  output var  logic                    arr_erase,
  output var  logic                    arr_verify,
  output var  logic [`FCRC_ADDR_W-1:0] arr_addr,
  output var  logic [7:0]              arr_wdata,
  output var  logic                    busy,
  output var  logic                    rejected
);
  // decoded once, used by the program write path only
  function automatic logic in_boot(input logic [`FCRC_ADDR_W-1:0] a);
    in_boot = (a >= `FCRC_BOOT_BASE) &&
              (a < `FCRC_BOOT_BASE + `FCRC_BOOT_SIZE);
  endfunction

  fcrc_op_if op_if ();
  fcrc_op_timer #(.ERASE_CYC(ERASE_CYC)) u_tmr (
    .clk_sys (clk_sys),
    .srst    (srst),
    .ce      (ce),
    .op_if   (op_if)
  );

  // pins are asynchronous: two flops before use
  logic [1:0] mode_s1_r;
  logic [1:0] mode_s2_r;
  logic       prot_s1_r;
  logic       prot_s2_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_s1_r <= 2'h0;
      mode_s2_r <= 2'h0;
      prot_s1_r <= 1'b0;
      prot_s2_r <= 1'b0;
    end else if (ce) begin
      mode_s1_r <= mode_pin;
      mode_s2_r <= mode_s1_r;
      prot_s1_r <= protect_pin;
      prot_s2_r <= prot_s1_r;
    end
  end

  fcrc_mode_t  mode;
  fcrc_state_t st_r;
  fcrc_state_t st_nxt;
  logic        rw_en_r;
  logic        rw_en_nxt;
  fcrc_op_t    pend_r;
  fcrc_op_t    pend_nxt;
  logic [`FCRC_ADDR_W-1:0] addr_r;
  logic [`FCRC_ADDR_W-1:0] addr_nxt;
  logic [7:0]  wdata_r;
  logic [7:0]  wdata_nxt;
  logic        verify_r;
  logic        verify_nxt;
  logic        rej_r;
  logic        rej_nxt;
  logic        start;
  logic        cmd_wr;
  logic        ctl_wr;
  logic        arr_wr;
  logic        boot_ok;

  assign mode    = fcrc_mode_t'(mode_s2_r);
  assign cmd_wr  = bus_wr && bus_addr == `FCRC_CMD_ADDR;
  assign ctl_wr  = bus_wr && bus_addr == `FCRC_CTRL0_ADDR;
  assign arr_wr  = bus_wr && !cmd_wr && bus_addr != `FCRC_CTRL0_ADDR &&
                   bus_addr != `FCRC_CTRL1_ADDR;
  // boot area only writable from parallel programmer mode
  assign boot_ok = (mode == FCRC_MODE_PARALLEL);

  always_comb begin
    st_nxt     = st_r;
    rw_en_nxt  = rw_en_r;
    pend_nxt   = FCRC_OP_NONE;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    verify_nxt = 1'b0;
    rej_nxt    = 1'b0;
    start      = 1'b0;
    if (ctl_wr && !op_if.busy)
      rw_en_nxt = bus_wdata[`FCRC_CTRL_RW_EN_BIT];
    if (op_if.busy) begin
      st_nxt = op_if.busy ? FCRC_ST_BUSY : st_r;
    end else if (st_r == FCRC_ST_BUSY) begin
      st_nxt = FCRC_ST_READ;
    end else begin
      case (st_r)
        FCRC_ST_PROG: begin
          if (arr_wr) begin
            addr_nxt  = bus_addr;
            wdata_nxt = bus_wdata;
            if (in_boot(bus_addr) && !boot_ok) begin
              rej_nxt = 1'b1;
              st_nxt  = FCRC_ST_READ;
            end else begin
              pend_nxt = FCRC_OP_PROG;
              start    = 1'b1;
              st_nxt   = FCRC_ST_BUSY;
            end
          end
        end
        FCRC_ST_ERASE: begin
          if (cmd_wr) begin
            if (bus_wdata == `FCRC_CMD_ERASE) begin
              pend_nxt = FCRC_OP_ERASE;
              start    = 1'b1;
              st_nxt   = FCRC_ST_BUSY;
            end else begin
              st_nxt = FCRC_ST_READ;
            end
          end
        end
        FCRC_ST_RESET: begin
          if (cmd_wr)
            st_nxt = FCRC_ST_READ;
        end
        FCRC_ST_PVERIFY, FCRC_ST_EVERIFY: begin
          if (bus_rd && bus_addr != `FCRC_CMD_ADDR) begin
            verify_nxt = 1'b1;
            st_nxt     = FCRC_ST_READ;
          end
        end
        default: ;
      endcase
      if (cmd_wr && st_r != FCRC_ST_ERASE && st_r != FCRC_ST_RESET) begin
        case (bus_wdata)
          `FCRC_CMD_READ:    st_nxt = FCRC_ST_READ;
          `FCRC_CMD_PROG:    st_nxt = FCRC_ST_PROG;
          `FCRC_CMD_PVERIFY: st_nxt = FCRC_ST_PVERIFY;
          `FCRC_CMD_ERASE:   st_nxt = FCRC_ST_ERASE;
          `FCRC_CMD_EVERIFY: st_nxt = FCRC_ST_EVERIFY;
          `FCRC_CMD_RESET:   st_nxt = FCRC_ST_RESET;
          default:           st_nxt = st_r;
        endcase
      end
    end
  end

  // erase starts in any mode with no boot area check;
  // only program writes pass through the boot_ok guard
  assign op_if.start = start;
  assign op_if.op    = pend_nxt;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r     <= FCRC_ST_READ;
      rw_en_r  <= 1'b0;
      pend_r   <= FCRC_OP_NONE;
      addr_r   <= '0;
      wdata_r  <= 8'h00;
      verify_r <= 1'b0;
      rej_r    <= 1'b0;
    end else if (ce) begin
      st_r     <= st_nxt;
      rw_en_r  <= rw_en_nxt;
      pend_r   <= pend_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      verify_r <= verify_nxt;
      rej_r    <= rej_nxt;
    end
  end

  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  always_comb begin
    rdata_nxt = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        `FCRC_CTRL0_ADDR: begin
          rdata_nxt[`FCRC_CTRL_BUSY_BIT]  = !op_if.busy;
          rdata_nxt[`FCRC_CTRL_RW_EN_BIT] = rw_en_r;
          rdata_nxt[`FCRC_CTRL_MON_BIT]   = rw_en_r;
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst)
      rdata_r <= 8'h00;
    else if (ce)
      rdata_r <= rdata_nxt;
  end

  assign bus_rdata   = rdata_r;
  assign fetch_block = (rw_en_r && mode == FCRC_MODE_CPU) ||
                       (prot_s2_r && mode == FCRC_MODE_PARALLEL);
  assign arr_prog    = pend_r == FCRC_OP_PROG;
  assign arr_erase   = pend_r == FCRC_OP_ERASE;
  assign arr_verify  = verify_r;
  assign arr_addr    = addr_r;
  assign arr_wdata   = wdata_r;
  assign busy        = op_if.busy;
  assign rejected    = rej_r;
endmodule
`default_nettype wire

// ==== verilog/fcrc_defines.svh ====
// constants for the flash rewrite control block
`ifndef FCRC_DEFINES_SVH
`define FCRC_DEFINES_SVH

`define FCRC_ADDR_W          20
`define FCRC_CTRL0_ADDR      20'h003B4
`define FCRC_CTRL1_ADDR      20'h003B5
`define FCRC_CMD_ADDR        20'h003B6
`define FCRC_BOOT_BASE       20'hFF000
`define FCRC_BOOT_SIZE       20'h00E00
`define FCRC_CMD_READ        8'h00
`define FCRC_CMD_PROG        8'h40
`define FCRC_CMD_PVERIFY     8'hC0
`define FCRC_CMD_ERASE       8'h20
`define FCRC_CMD_EVERIFY     8'hA0
`define FCRC_CMD_RESET       8'hFF
`define FCRC_CTRL_RW_EN_BIT  1
`define FCRC_CTRL_BUSY_BIT   0
`define FCRC_CTRL_MON_BIT    3
`define FCRC_CLK_MHZ         100
`define FCRC_PROG_TIME_US    20
`define FCRC_ERASE_TIME_MS   20
`define FCRC_PROG_CYC        (`FCRC_PROG_TIME_US * `FCRC_CLK_MHZ)
`define FCRC_ERASE_CYC       (`FCRC_ERASE_TIME_MS * 1000 * `FCRC_CLK_MHZ)

`endif

// ==== verilog/fcrc_op_if.sv ====
// operation request and completion between sequencer and op timer
`timescale 1ns/100ps
`default_nettype none
interface fcrc_op_if;
  import fcrc_pkg::*;
  logic     start;
  fcrc_op_t op;
  logic     busy;
  logic     done;
  modport seq (output start, output op, input busy, input done);
  modport tmr (input start, input op, output busy, output done);
endinterface
`default_nettype wire

// ==== verilog/fcrc_op_timer.sv ====
// times a program or erase pulse and reports busy and completion
`timescale 1ns/100ps
`default_nettype none
`include "fcrc_defines.svh"
module fcrc_op_timer
  import fcrc_pkg::*;
#(
  parameter int unsigned ERASE_CYC = `FCRC_ERASE_CYC
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic ce,
  fcrc_op_if.tmr    op_if
);
  localparam int unsigned PROG_CYC = `FCRC_PROG_CYC;

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic        done_r;
  logic        done_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (busy_r) begin
      if (cnt_r <= 32'h00000001) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        cnt_nxt  = 32'h00000000;
      end else begin
        cnt_nxt = cnt_r - 32'h00000001;
      end
    end else if (op_if.start && op_if.op != FCRC_OP_NONE) begin
      busy_nxt = 1'b1;
      cnt_nxt  = (op_if.op == FCRC_OP_ERASE) ? ERASE_CYC : PROG_CYC;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r  <= 32'h00000000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign op_if.busy = busy_r;
  assign op_if.done = done_r;
endmodule
`default_nettype wire

// ==== verilog/fcrc_pkg.sv ====
// types for the flash rewrite control block
package fcrc_pkg;
  typedef enum logic [1:0] {
    FCRC_MODE_CPU      = 2'h0,
    FCRC_MODE_PARALLEL = 2'h1,
    FCRC_MODE_SERIAL   = 2'h3
  } fcrc_mode_t;

  typedef enum logic [2:0] {
    FCRC_ST_READ    = 3'h0,
    FCRC_ST_PROG    = 3'h1,
    FCRC_ST_BUSY    = 3'h3,
    FCRC_ST_ERASE   = 3'h2,
    FCRC_ST_PVERIFY = 3'h6,
    FCRC_ST_EVERIFY = 3'h7,
    FCRC_ST_RESET   = 3'h5
  } fcrc_state_t;

  typedef enum logic [1:0] {
    FCRC_OP_NONE  = 2'h0,
    FCRC_OP_PROG  = 2'h1,
    FCRC_OP_ERASE = 2'h2
  } fcrc_op_t;
endpackage
